//--- rtl/fac_consts.vh
// Register offsets, field positions, codes and reset values
`ifndef FAC_CONSTS_VH
`define FAC_CONSTS_VH
`define FAC_ADDR_W 4
`define FAC_OFS_PFA_S 4'h0
`define FAC_OFS_PFA_NS 4'h1
`define FAC_OFS_BEA 4'h2
`define FAC_OFS_CPC_S 4'h3
`define FAC_OFS_CPC_NS 4'h4
`define FAC_OFS_STATUS 4'h5
`define FAC_STS_PVALID_S 0
`define FAC_STS_PVALID_NS 1
`define FAC_STS_BVALID 2
`define FAC_FP1_LO 20
`define FAC_FP1_HI 21
`define FAC_FP2_LO 22
`define FAC_FP2_HI 23
`define FAC_CODE_DENY 2'h0
`define FAC_CODE_PRIV 2'h1
`define FAC_CODE_FULL 2'h3
`define FAC_ADDR_RST 32'h00000000
`define FAC_CPC_RST 32'h00000000
`endif

//--- rtl/fac_fault_access.v
// Fault address capture and coprocessor privilege control
// Register index map (word index on the register port)
//   0 protection fault address, secure bank
//   1 protection fault address, non-secure bank
//   2 bus error fault address, shared by both states
//   3 privilege control, secure bank
//   4 privilege control, non-secure bank
//   5 valid flags: bit 0 secure, bit 1 non-secure, bit 2 bus
//   others read zero, writes dropped
//
// Capture takes priority over a software write or a valid clear
// in the same cycle, so a fault is never lost to a racing handler.
// Handlers must read the address before the flag; a later fault
// may overwrite the address between the two reads.
//
// Without security states the non-secure banks are absent: they
// read zero, ignore writes, and every protection fault and access uses the
// secure bank.
//
// Privilege control layout
//   31:24 reserved, read zero
//   23:22 secondary float field, stored, not decoded
//   21:20 primary float field
//   19:16 reserved, read zero
//   15:0  eight two-bit coprocessor fields, m at 2m+1:2m
//
// Privilege codes
//   00 deny: every access raises the absent-coprocessor fault
//   01 privileged only: unprivileged access faults
//   10 reserved: treated as deny
//   11 full access
//
// Software should keep the secondary float field equal to the
// primary one; on a mismatch the stored bits read back as they
// were written.
//
// Fault capture inputs are single-cycle pulses from the core;
// the address beside each pulse is taken in that same cycle.
// Protection faults record the address that actually faulted,
// which for a split unaligned access may be any byte of it;
// bus errors record the address the instruction requested.
// Coprocessor verdicts are combinational from the request and
// the selected privilege bank, so they follow the request.
//
// Unmapped indices, reserved bits and absent units read zero and
// drop writes; nothing here raises an interrupt of its own.
//
// The valid-flag clears come from the status logic that owns the
// write-one-to-clear status bits; a clear in the cycle of a new
// fault loses to the fault.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "fac_consts.vh"
module fac_fault_access #(
  parameter HAS_FPU = 1,
  parameter HAS_SECURITY = 1,
  parameter [7:0] CP_PRESENT = 8'hff
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Register port
  input wire [`FAC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  // Protection fault report
  input wire prot_fault,
  input wire prot_fault_secure,
  input wire [31:0] prot_actual_addr,
  // Bus error report
  input wire bus_fault,
  input wire [31:0] bus_req_addr,
  // Valid flag clears from the fault status logic
  input wire prot_valid_clr_s,
  input wire prot_valid_clr_ns,
  input wire bus_valid_clr,
  // Coprocessor access request
  input wire cp_req,
  input wire cp_is_float,
  input wire [2:0] cp_num,
  input wire cp_privileged,
  input wire cp_secure,
  output wire cp_grant,
  output wire cp_absent_fault,
  // Valid flags out
  output wire protection_address_valid_s,
  output wire protection_address_valid_ns,
  output wire bus_error_address_valid
);
  // Address, flag and privilege state
  reg [31:0] pfa_s_q;
  reg [31:0] pfa_ns_q;
  reg [31:0] bea_q;
  reg [31:0] cpc_s_q;
  reg [31:0] cpc_ns_q;
  reg pv_s_q;
  reg pv_ns_q;
  reg bv_q;

  // Read path
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // Mask and decode nets
  wire [31:0] cpc_mask;
  wire [31:0] cpc_w;
  wire ns_fault;
  wire [31:0] cpc_sel;
  wire [1:0] code;
  wire present;
  wire [15:0] cp_pmask;
  wire wr_pfa_s;
  wire wr_pfa_ns;
  wire wr_bea;

  // Write decode for privilege banks
  wire wr_cpc_s;
  wire wr_cpc_ns;

  // Bank steering and field decode
  wire s_fault;
  wire sec_on;
  wire [1:0] fp_code;
  wire [1:0] cp_code;
  wire [3:0] fp_mask;
  wire [31:0] pfa_ns_rd;
  wire [31:0] cpc_ns_rd;
  wire [31:0] status_word;

  // Next values
  reg [31:0] pfa_s_d;
  reg [31:0] pfa_ns_d;
  reg [31:0] bea_d;
  reg pv_s_d;
  reg pv_ns_d;
  reg bv_d;
  reg [31:0] cpc_s_d;
  reg [31:0] cpc_ns_d;

  // Writable bits: implemented coprocessors, float fields if present
  genvar m;
  generate
    for (m = 0; m < 8; m = m + 1) begin : g_cp
      assign cp_pmask[2*m+1:2*m] = {2{CP_PRESENT[m]}};
    end
  endgenerate
  // Float fields writable only with a float unit
  assign fp_mask = {4{HAS_FPU != 0}};
  // Secondary float field stored as written
  assign cpc_mask = {8'h00, fp_mask, 4'h0, cp_pmask};
  assign cpc_w = reg_wdata & cpc_mask;

  // Security states present; non-secure banks exist only then
  assign sec_on = (HAS_SECURITY != 0);
  // Fault bank steering: secure bank unless a non-secure fault
  assign ns_fault = sec_on && !prot_fault_secure;
  assign s_fault = prot_fault && !ns_fault;
  // Write decode, one strobe per writable register
  assign wr_pfa_s = reg_wr && (reg_addr == `FAC_OFS_PFA_S);
  assign wr_pfa_ns = reg_wr && (reg_addr == `FAC_OFS_PFA_NS) && sec_on;
  assign wr_bea = reg_wr && (reg_addr == `FAC_OFS_BEA);
  assign wr_cpc_s = reg_wr && (reg_addr == `FAC_OFS_CPC_S);
  assign wr_cpc_ns = reg_wr && (reg_addr == `FAC_OFS_CPC_NS) && sec_on;

  // Secure protection bank next value
  // Capture beats a same-cycle write or clear
  always @* begin
    pfa_s_d = pfa_s_q;
    pv_s_d = pv_s_q;
    if (s_fault) begin
      pfa_s_d = prot_actual_addr;
      pv_s_d = 1'b1;
    end else begin
      if (wr_pfa_s) begin
        pfa_s_d = reg_wdata;
      end
      if (prot_valid_clr_s) begin
        pv_s_d = 1'b0;
      end
    end
  end

  // Non-secure protection bank next value
  // Only reached when security states exist
  always @* begin
    pfa_ns_d = pfa_ns_q;
    pv_ns_d = pv_ns_q;
    if (prot_fault && ns_fault) begin
      pfa_ns_d = prot_actual_addr;
      pv_ns_d = 1'b1;
    end else begin
      if (wr_pfa_ns) begin
        pfa_ns_d = reg_wdata;
      end
      if (prot_valid_clr_ns) begin
        pv_ns_d = 1'b0;
      end
    end
  end

  // Shared bus error address next value
  // Requested address, whichever state faulted
  always @* begin
    bea_d = bea_q;
    bv_d = bv_q;
    if (bus_fault) begin
      bea_d = bus_req_addr;
      bv_d = 1'b1;
    end else begin
      if (wr_bea) begin
        bea_d = reg_wdata;
      end
      if (bus_valid_clr) begin
        bv_d = 1'b0;
      end
    end
  end

  // Fault address and valid flag registers, one update
  // so a flag never runs ahead of its address
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pfa_s_q <= `FAC_ADDR_RST;
      pfa_ns_q <= `FAC_ADDR_RST;
      bea_q <= `FAC_ADDR_RST;
      pv_s_q <= 1'b0;
      pv_ns_q <= 1'b0;
      bv_q <= 1'b0;
    end else begin
      pfa_s_q <= pfa_s_d;
      pfa_ns_q <= pfa_ns_d;
      bea_q <= bea_d;
      pv_s_q <= pv_s_d;
      pv_ns_q <= pv_ns_d;
      bv_q <= bv_d;
    end
  end

  // Privilege control next values, masked writes
  always @* begin
    cpc_s_d = cpc_s_q;
    cpc_ns_d = cpc_ns_q;
    if (wr_cpc_s) begin
      cpc_s_d = cpc_w;
    end
    if (wr_cpc_ns) begin
      cpc_ns_d = cpc_w;
    end
  end

  // Privilege control banks
  always @(posedge sys_clk) begin
    if (!nrst) begin
      cpc_s_q <= `FAC_CPC_RST;
      cpc_ns_q <= `FAC_CPC_RST;
    end else begin
      cpc_s_q <= cpc_s_d;
      cpc_ns_q <= cpc_ns_d;
    end
  end

  // Bank select by the requester's security state
  assign cpc_sel = (sec_on && !cp_secure) ? cpc_ns_q : cpc_s_q;
  // Float decision reads the primary field; secondary ignored
  assign fp_code = cpc_sel[`FAC_FP1_HI:`FAC_FP1_LO];
  // Coprocessor field m sits at bits 2m+1:2m
  assign cp_code = cpc_sel[{cp_num, 1'b1} -: 2];
  assign code = cp_is_float ? fp_code : cp_code;
  // Absent units always refuse
  assign present = cp_is_float ? (HAS_FPU != 0) :
    CP_PRESENT[cp_num];

  // Privilege verdict for the selected field
  fac_priv_check u_check (
    .code(code),
    .present(present),
    .privileged(cp_privileged),
    .request(cp_req),
    .grant(cp_grant),
    .fault(cp_absent_fault)
  );

  // Absent non-secure banks read zero
  assign pfa_ns_rd = sec_on ? pfa_ns_q : 32'h00000000;
  assign cpc_ns_rd = sec_on ? cpc_ns_q : 32'h00000000;

  // Valid flags as seen by software
  assign status_word = {29'h0, bv_q, pv_ns_q, pv_s_q};

  // Read mux, data one cycle after the strobe
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `FAC_OFS_PFA_S: rdata_d = pfa_s_q;
      `FAC_OFS_PFA_NS: rdata_d = pfa_ns_rd;
      `FAC_OFS_BEA: rdata_d = bea_q;
      `FAC_OFS_CPC_S: rdata_d = cpc_s_q;
      `FAC_OFS_CPC_NS: rdata_d = cpc_ns_rd;
      `FAC_OFS_STATUS: rdata_d = status_word;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Read data register: stands one cycle, zero otherwise
  always @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  // Read data and flags to the status logic
  assign reg_rdata = rdata_q;
  assign protection_address_valid_s = pv_s_q;
  assign protection_address_valid_ns = pv_ns_q;
  assign bus_error_address_valid = bv_q;
endmodule // fac_fault_access

//--- rtl/fac_priv_check.v
// Privilege code decode: grants or refuses one access
`timescale 1ns/100ps
`include "fac_consts.vh"
module fac_priv_check (
  // Field and request
  input wire [1:0] code,
  input wire present,
  input wire privileged,
  input wire request,
  // Verdict
  output wire grant,
  output wire fault
);
  // Absent units refuse; full grants all, privileged-only needs privilege, others refuse
  wire ok;
  assign ok = present && ((code == `FAC_CODE_FULL) ||
    ((code == `FAC_CODE_PRIV) && privileged));
  assign grant = request && ok;
  assign fault = request && !ok;
endmodule // fac_priv_check

//--- test/fac_fault_access_sva.sv
// Assertions on fault address capture and privilege decisions
`timescale 1ns/100ps
module fac_fault_access_sva (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Register port
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Fault reports and clears
  input wire prot_fault,
  input wire prot_fault_secure,
  input wire bus_fault,
  input wire [31:0] bus_req_addr,
  input wire bus_valid_clr,
  input wire prot_valid_clr_s,
  // Coprocessor access
  input wire cp_req,
  input wire cp_grant,
  input wire cp_absent_fault,
  // Valid flags
  input wire protection_address_valid_s,
  input wire protection_address_valid_ns,
  input wire bus_error_address_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Bus fault followed two cycles later by a read of its address
  sequence bus_cap;
    bus_fault ##1 (!bus_fault && !reg_wr) ##1
      (reg_rd && reg_addr == 4'h2 && !bus_fault && !reg_wr);
  endsequence
  pvs_set_a: assert property (prot_fault && prot_fault_secure |=>
    protection_address_valid_s) else $error("secure valid not set");
  pvns_set_a: assert property (prot_fault && !prot_fault_secure |=>
    protection_address_valid_ns) else $error("nonsecure valid not set");
  bv_set_a: assert property (bus_fault |=> bus_error_address_valid)
    else $error("bus valid not set");
  pv_hold_a: assert property (protection_address_valid_s &&
    !prot_valid_clr_s |=> protection_address_valid_s)
    else $error("secure valid dropped");
  bv_clr_a: assert property (bus_valid_clr && !bus_fault |=>
    !bus_error_address_valid) else $error("bus valid not cleared");
  bus_read_a: assert property (bus_cap |=>
    reg_rdata == $past(bus_req_addr, 3)) else $error("bus address lost");
  cp_excl_a: assert property (cp_req |-> cp_grant != cp_absent_fault)
    else $error("grant and fault not exclusive");
  cp_idle_a: assert property (!cp_req |-> !cp_grant &&
    !cp_absent_fault) else $error("verdict without request");
endmodule // fac_fault_access_sva
bind fac_fault_access fac_fault_access_sva u_sva (.*);

//--- test/fac_fault_access_tb.sv
// Testbench for fault address capture and privilege control
`timescale 1ns/100ps
module fac_fault_access_tb;
  reg sys_clk = 0, nrst = 0, wr = 0, rd = 0, pf = 0, ps = 0, bf = 0;
  reg clr_b = 0, rq = 0, fl = 0, pv = 0, sc = 0, clr_s = 0, clr_n = 0;
  reg [3:0] a = 0;
  reg [2:0] cn = 0;
  reg [31:0] wd = 0, pa = 0, ba = 0;
  wire [31:0] rdata;
  wire gnt, flt, vs, vn, vb;
  integer failures = 0, cmp_count = 0, c, p;
  fac_fault_access u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .prot_fault(pf), .prot_fault_secure(ps), .prot_actual_addr(pa),
    .bus_fault(bf), .bus_req_addr(ba), .prot_valid_clr_s(clr_s),
    .prot_valid_clr_ns(clr_n), .bus_valid_clr(clr_b), .cp_req(rq),
    .cp_is_float(fl), .cp_num(cn), .cp_privileged(pv), .cp_secure(sc),
    .cp_grant(gnt), .cp_absent_fault(flt),
    .protection_address_valid_s(vs), .protection_address_valid_ns(vn),
    .bus_error_address_valid(vb));
  // Free running clock
  initial forever #4 sys_clk = ~sys_clk;
  task chk(input [47:0] n, input [31:0] e, input [31:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("ERROR %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  task wrt(input [3:0] ad, input [31:0] d);
    begin
      @(posedge sys_clk); a <= ad; wd <= d; wr <= 1;
      @(posedge sys_clk); wr <= 0;
    end
  endtask
  task rdc(input [3:0] ad, input [31:0] e);
    begin
      @(posedge sys_clk); a <= ad; rd <= 1;
      @(posedge sys_clk); rd <= 0;
      #1 chk("rdata", e, rdata);
    end
  endtask
  task cpc(input f, input [2:0] n, input pr, input s, input g);
    begin
      @(posedge sys_clk); rq <= 1; fl <= f; cn <= n; pv <= pr; sc <= s;
      #2 chk("grant", {31'h0, g}, {31'h0, gnt});
      chk("fault", {31'h0, !g}, {31'h0, flt});
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    #20000 failures = failures + 1;
    conclude;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1;
    rdc(4'h5, 0);
    wrt(4'h3, 32'hffffffff); rdc(4'h3, 32'h00f0ffff);
    wrt(4'h4, 0);
    for (c = 0; c < 4; c = c + 1) begin
      wrt(4'h3, {8'h0, c[1:0], c[1:0], 4'h0, {8{c[1:0]}}});
      for (p = 0; p < 2; p = p + 1) begin
        cpc(0, 3'h5, p[0], 1, c == 3 || (c == 1 && p == 1));
        cpc(1, 3'h0, p[0], 1, c == 3 || (c == 1 && p == 1));
      end
    end
    cpc(1, 3'h0, 1, 0, 0);
    wrt(4'h3, 32'h00300000); cpc(1, 3'h0, 0, 1, 1);
    @(posedge sys_clk); rq <= 0; pf <= 1; ps <= 1; pa <= 32'h20000003;
    @(posedge sys_clk); ps <= 0; pa <= 32'h20000101;
    @(posedge sys_clk); pf <= 0; bf <= 1; ba <= 32'h40000002;
    @(posedge sys_clk); bf <= 0;
    rdc(4'h2, 32'h40000002);
    rdc(4'h0, 32'h20000003);
    rdc(4'h1, 32'h20000101);
    rdc(4'h5, 32'h7);
    rdc(4'h7, 0);
    @(posedge sys_clk); clr_b <= 1;
    @(posedge sys_clk); clr_b <= 0;
    rdc(4'h5, 32'h3);
    @(posedge sys_clk); clr_s <= 1; clr_n <= 1; bf <= 1; clr_b <= 1;
    ba <= 32'h40000010;
    @(posedge sys_clk); clr_s <= 0; clr_n <= 0; bf <= 0; clr_b <= 0;
    #1 chk("flags", 32'h4, {29'h0, vb, vn, vs});
    rdc(4'h2, 32'h40000010);
    rdc(4'h5, 32'h4);
    conclude;
  end
endmodule // fac_fault_access_tb
